/* File: agfs_pkg.sv */
/*
 * Package for the per-axis pin function block: register byte offsets,
 * field layout, function codes, reset values and the drive status carrier.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
`default_nettype none

package agfs_pkg;

   // Geometry.
   localparam int AXES = 4;
   localparam int PINS = 8;
   localparam int FN_W = 2;
   localparam int WORD_W = 16;

   // Register byte offsets.
   localparam logic [7:0] OFS_COMMAND = 8'h00;
   localparam logic [7:0] OFS_DATA_WRITE_LOW_WORD = 8'h04;
   localparam logic [7:0] OFS_OUTPUT_DATA_FIRST = 8'h08;
   localparam logic [7:0] OFS_OUTPUT_DATA_SECOND = 8'h0c;
   localparam logic [7:0] OFS_PIN_LEVEL_XY_AXES = 8'h10;
   localparam logic [7:0] OFS_PIN_LEVEL_ZU_AXES = 8'h14;
   localparam logic [7:0] OFS_EXT_DRIVE_CTRL = 8'h18;
   localparam logic [7:0] OFS_SYNC_EDGE_SELECT = 8'h1c;

   // Command register fields.
   localparam int CMD_CODE_LSB = 0;
   localparam int CMD_CODE_W = 8;
   localparam int CMD_AXIS_LSB = 8;
   localparam logic [7:0] CMD_PIN_FUNCTION_SET = 8'h21;

   // External drive control fields: enable per axis, then mode per axis.
   localparam int EXT_EN_LSB = 0;
   localparam int EXT_MODE_LSB = 4;

   // Pins that start external-signal driving, and the last pin that carries a sync pulse.
   localparam int PIN_REL_START = 4;
   localparam int PIN_CONT_START = 5;
   localparam int PIN_SYNC_LAST = 3;

   // Function codes of one two-bit field.
   localparam logic [1:0] FN_GP_INPUT = 2'h0;
   localparam logic [1:0] FN_GP_OUTPUT = 2'h1;
   localparam logic [1:0] FN_DRIVE_STATUS = 2'h2;
   localparam logic [1:0] FN_SYNC_COMPARE = 2'h3;

   // Reset values.
   localparam logic [15:0] RST_PIN_FUNCTION = 16'h0000;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [7:0] RST_EXT_CTRL = 8'h00;
   localparam logic [31:0] RST_SYNC_EDGE = 32'h0000_0000;

   // Drive state of one axis as seen from the motion logic.
   typedef struct packed {
      logic decelerating;
      logic accelerating;
      logic driving;
   } agfs_drive_status_t;

endpackage : agfs_pkg

`default_nettype wire

/* File: agfs_gpio.sv */
/*
 * Per-axis general purpose pin block with function select, APB registers,
 * pin level read-back, synchronous trigger events and external drive start.
 * Assumes pin levels, drive status, sync pulses and compare results are
 * synchronous to pclk; the bench resolves each pin wire from pin_oe_n.
 */
// Our own choices: the APB register port and the register offsets.
`default_nettype none

module agfs_gpio #(
   parameter int AXES = agfs_pkg::AXES,
   parameter int PINS = agfs_pkg::PINS
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Pins, axis a pin k at index a*PINS+k
   input wire logic [AXES*PINS-1:0] axis_io_pin_in,
   output logic [AXES*PINS-1:0] axis_io_pin_out,
   output logic [AXES*PINS-1:0] axis_io_pin_oe_n,
   // Motion logic sources
   input wire agfs_pkg::agfs_drive_status_t [AXES-1:0] drive_status,
   input wire logic [AXES*4-1:0] sync_pulse,
   input wire logic [AXES*4-1:0] compare_result,
   // Events towards motion logic
   output logic [AXES*PINS-1:0] sync_trigger,
   output logic [AXES-1:0] ext_rel_start,
   output logic [AXES-1:0] ext_cont_start
);

   localparam int NP = AXES * PINS;

   logic [15:0] pin_function_reg [AXES];
   logic [15:0] data_write_low_word_reg;
   logic [15:0] output_data_first_reg;
   logic [15:0] output_data_second_reg;
   logic [7:0] ext_ctrl_reg;
   logic [31:0] sync_edge_reg;
   logic [NP-1:0] level_reg;
   logic [NP-1:0] level_prev_reg;
   logic [1:0] primed_reg;
   logic [NP-1:0] out_next;
   logic [NP-1:0] oe_n_next;
   logic [NP-1:0] trig_next;
   logic [AXES-1:0] rel_next;
   logic [AXES-1:0] cont_next;
   logic [31:0] rdata_next;
   logic err_next;
   logic [31:0] gp_out_bits;
   logic access;
   logic wr_fire;
   logic cmd_fire;

   // Every access answers in its second access cycle; the write lands then.
   assign access = psel & penable & ~pready;
   assign wr_fire = psel & penable & pready & pwrite;
   assign cmd_fire = wr_fire && (paddr == agfs_pkg::OFS_COMMAND)
      && (pwdata[agfs_pkg::CMD_CODE_LSB +: agfs_pkg::CMD_CODE_W]
          == agfs_pkg::CMD_PIN_FUNCTION_SET);
   assign gp_out_bits = {output_data_second_reg, output_data_first_reg};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
      end
      else
      begin
         pready <= access;
      end
   end

   always_comb
   begin
      rdata_next = 32'h0000_0000;
      err_next = 1'b0;
      unique case (paddr)
         agfs_pkg::OFS_COMMAND:
         begin
            err_next = ~pwrite;
         end
         agfs_pkg::OFS_DATA_WRITE_LOW_WORD:
         begin
            rdata_next = {16'h0000, data_write_low_word_reg};
         end
         agfs_pkg::OFS_OUTPUT_DATA_FIRST:
         begin
            rdata_next = {16'h0000, output_data_first_reg};
         end
         agfs_pkg::OFS_OUTPUT_DATA_SECOND:
         begin
            rdata_next = {16'h0000, output_data_second_reg};
         end
         agfs_pkg::OFS_PIN_LEVEL_XY_AXES:
         begin
            rdata_next = {16'h0000, level_reg[15:0]};
            err_next = pwrite;
         end
         agfs_pkg::OFS_PIN_LEVEL_ZU_AXES:
         begin
            rdata_next = {16'h0000, level_reg[31:16]};
            err_next = pwrite;
         end
         agfs_pkg::OFS_EXT_DRIVE_CTRL:
         begin
            rdata_next = {24'h000000, ext_ctrl_reg};
         end
         agfs_pkg::OFS_SYNC_EDGE_SELECT:
         begin
            rdata_next = sync_edge_reg;
         end
         default:
         begin
            err_next = 1'b1;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (access)
      begin
         prdata <= pwrite ? 32'h0000_0000 : rdata_next;
         pslverr <= err_next;
      end
      else
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         data_write_low_word_reg <= agfs_pkg::RST_WORD;
         output_data_first_reg <= agfs_pkg::RST_WORD;
         output_data_second_reg <= agfs_pkg::RST_WORD;
         ext_ctrl_reg <= agfs_pkg::RST_EXT_CTRL;
         sync_edge_reg <= agfs_pkg::RST_SYNC_EDGE;
      end
      else if (wr_fire)
      begin
         if (paddr == agfs_pkg::OFS_DATA_WRITE_LOW_WORD)
         begin
            data_write_low_word_reg <= pwdata[15:0];
         end
         if (paddr == agfs_pkg::OFS_OUTPUT_DATA_FIRST)
         begin
            output_data_first_reg <= pwdata[15:0];
         end
         if (paddr == agfs_pkg::OFS_OUTPUT_DATA_SECOND)
         begin
            output_data_second_reg <= pwdata[15:0];
         end
         if (paddr == agfs_pkg::OFS_EXT_DRIVE_CTRL)
         begin
            ext_ctrl_reg <= pwdata[7:0];
         end
         if (paddr == agfs_pkg::OFS_SYNC_EDGE_SELECT)
         begin
            sync_edge_reg <= pwdata;
         end
      end
   end

   // Pin levels are sampled once; the read-back shows the wire, not the driver.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         level_reg <= '0;
         level_prev_reg <= '0;
      end
      else
      begin
         level_reg <= axis_io_pin_in;
         level_prev_reg <= level_reg;
      end
   end

   // The previous sample only means something from the second edge after reset;
   // without this gate a pin that idles high would raise a false edge event.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         primed_reg <= 2'h0;
      end
      else
      begin
         primed_reg <= {primed_reg[0], 1'h1};
      end
   end

   genvar a;
   genvar k;
   generate
      for (a = 0; a < AXES; a++)
      begin : g_axis
         logic ext_en;
         logic ext_change;
         logic rel_in;
         logic cont_in;

         // One command may load several axes at once through the axis mask.
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               pin_function_reg[a] <= agfs_pkg::RST_PIN_FUNCTION;
            end
            else if (cmd_fire && pwdata[agfs_pkg::CMD_AXIS_LSB + a])
            begin
               pin_function_reg[a] <= data_write_low_word_reg;
            end
         end

         for (k = 0; k < PINS; k++)
         begin : g_pin
            localparam int P = a * PINS + k;
            logic [1:0] fn;
            logic rise;
            logic fall;
            logic src;

            assign fn = pin_function_reg[a][2*k +: agfs_pkg::FN_W];
            assign rise = level_reg[P] & ~level_prev_reg[P] & primed_reg[1];
            assign fall = ~level_reg[P] & level_prev_reg[P] & primed_reg[1];

            always_comb
            begin
               src = 1'b0;
               unique case (fn)
                  agfs_pkg::FN_GP_INPUT:
                  begin
                     src = 1'b0;
                  end
                  agfs_pkg::FN_GP_OUTPUT:
                  begin
                     src = gp_out_bits[P];
                  end
                  agfs_pkg::FN_DRIVE_STATUS:
                  begin
                     src = drive_status[a][k % 3];
                  end
                  agfs_pkg::FN_SYNC_COMPARE:
                  begin
                     if (k <= agfs_pkg::PIN_SYNC_LAST)
                     begin
                        src = sync_pulse[a*4 + (k % 4)];
                     end
                     else
                     begin
                        src = compare_result[a*4 + (k % 4)];
                     end
                  end
               endcase
            end

            assign out_next[P] = src;
            assign oe_n_next[P] = (fn == agfs_pkg::FN_GP_INPUT);
            // Triggers only count while the pin is an input.
            assign trig_next[P] = (fn == agfs_pkg::FN_GP_INPUT)
               && (sync_edge_reg[P] ? fall : rise);
         end

         // A disabled external drive leaves pins 4 and 5 as plain inputs.
         assign ext_en = ext_ctrl_reg[agfs_pkg::EXT_EN_LSB + a];
         assign ext_change = ext_ctrl_reg[agfs_pkg::EXT_MODE_LSB + a];
         assign rel_in = (g_pin[agfs_pkg::PIN_REL_START].fn == agfs_pkg::FN_GP_INPUT)
            && (ext_change
                ? (level_reg[a*PINS + agfs_pkg::PIN_REL_START]
                   & ~level_prev_reg[a*PINS + agfs_pkg::PIN_REL_START] & primed_reg[1])
                : level_reg[a*PINS + agfs_pkg::PIN_REL_START]);
         assign cont_in = (g_pin[agfs_pkg::PIN_CONT_START].fn == agfs_pkg::FN_GP_INPUT)
            && (ext_change
                ? (level_reg[a*PINS + agfs_pkg::PIN_CONT_START]
                   & ~level_prev_reg[a*PINS + agfs_pkg::PIN_CONT_START] & primed_reg[1])
                : level_reg[a*PINS + agfs_pkg::PIN_CONT_START]);
         assign rel_next[a] = ext_en & rel_in;
         assign cont_next[a] = ext_en & cont_in;
      end
   endgenerate

   // Outputs are registered so the pads see clean edges; this costs one cycle.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         axis_io_pin_out <= '0;
         axis_io_pin_oe_n <= '1;
      end
      else
      begin
         axis_io_pin_out <= out_next;
         axis_io_pin_oe_n <= oe_n_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sync_trigger <= '0;
         ext_rel_start <= '0;
         ext_cont_start <= '0;
      end
      else
      begin
         sync_trigger <= trig_next;
         ext_rel_start <= rel_next;
         ext_cont_start <= cont_next;
      end
   end

endmodule : agfs_gpio

`default_nettype wire

/* File: agfs_gpio_monitor.sv */
/*
 * Checker for the per-axis pin function block, bound to its top module.
 * Assumes one clock and the asynchronous active-low reset of the block.
 */
`default_nettype none

module agfs_gpio_monitor #(
   parameter int AXES = 4,
   parameter int PINS = 8
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Pins
   input wire logic [AXES*PINS-1:0] axis_io_pin_in,
   input wire logic [AXES*PINS-1:0] axis_io_pin_out,
   input wire logic [AXES*PINS-1:0] axis_io_pin_oe_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_take;
      psel && penable && !pready;
   endsequence
   sequence s_done;
      pready ##1 !pready;
   endsequence

   property p_answer;
      s_take |=> s_done;
   endproperty
   a_answer: assert property (p_answer) else $error("missing single ready pulse");
   property p_idle;
      !(psel && penable) |=> !pready;
   endproperty
   a_idle: assert property (p_idle) else $error("ready without access");
   property p_quiet;
      !pready |-> prdata == 32'h0000_0000;
   endproperty
   a_quiet: assert property (p_quiet) else $error("read data outside answer");
   property p_unmapped;
      (s_take and (paddr > agfs_pkg::OFS_SYNC_EDGE_SELECT))
         |=> pslverr && prdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
   property p_ro;
      (s_take and (pwrite && (paddr == agfs_pkg::OFS_PIN_LEVEL_XY_AXES
         || paddr == agfs_pkg::OFS_PIN_LEVEL_ZU_AXES))) |=> pslverr;
   endproperty
   a_ro: assert property (p_ro) else $error("level register write accepted");
   // Read-back passes through one sampling stage before the read register.
   property p_level;
      (s_take and (!pwrite && paddr == agfs_pkg::OFS_PIN_LEVEL_XY_AXES))
         |=> prdata == {16'h0000, $past(axis_io_pin_in[15:0], 2)};
   endproperty
   a_level: assert property (p_level) else $error("level read-back wrong");
   property p_drive;
      (axis_io_pin_out & axis_io_pin_oe_n) == '0;
   endproperty
   a_drive: assert property (p_drive) else $error("value on undriven pin");
   property p_reset_idle;
      $rose(presetn) |-> &axis_io_pin_oe_n;
   endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("pin driven after reset");
endmodule : agfs_gpio_monitor

bind agfs_gpio agfs_gpio_monitor #(.AXES(AXES), .PINS(PINS)) i_agfs_gpio_monitor (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .axis_io_pin_in(axis_io_pin_in),
   .axis_io_pin_out(axis_io_pin_out),
   .axis_io_pin_oe_n(axis_io_pin_oe_n)
);

`default_nettype wire

/* File: agfs_pins_model.sv */
/*
 * Machine side of the pins: resolves each wire from the device drivers.
 * Assumes the machine drives every pin that the device releases.
 */
`default_nettype none

module agfs_pins_model #(
   parameter int W = 32
) (
   // Machine levels
   input wire logic [W-1:0] ext_level,
   // Device drivers
   input wire logic [W-1:0] pin_out,
   input wire logic [W-1:0] pin_oe_n,
   // Resolved wire
   output logic [W-1:0] pin_wire
);
   timeunit 1ns;
   timeprecision 1ps;
   // A released pin never floats, so read-back never sees an unknown.
   assign pin_wire = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule : agfs_pins_model

`default_nettype wire

/* File: axis_gpio_function_select_test.sv */
/*
 * Self-checking bench for the per-axis pin function block over APB.
 * Assumes the pin model resolves every wire and pclk runs at 100 MHz.
 */
`default_nettype none

module axis_gpio_function_select_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, pins, pout, poe_n, trig, r, ex, eo;
   logic [31:0] ext = 32'ha5c3_3cc2;
   logic [31:0] dat = 32'h69a5_c35a;
   logic pready, pslverr;
   logic [3:0] rel, cont;
   logic [15:0] w;
   logic [15:0] sp = 16'hc639;
   logic [15:0] cr = 16'h1e87;
   agfs_pkg::agfs_drive_status_t [3:0] ds = 12'h5b3;
   int fail_count = 0;
   int compares = 0;
   int k, cd;

   always #5 pclk = ~pclk;

   agfs_pins_model i_agfs_pins_model (.ext_level(ext), .pin_out(pout), .pin_oe_n(poe_n),
      .pin_wire(pins));
   agfs_gpio i_agfs_gpio (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .axis_io_pin_in(pins), .axis_io_pin_out(pout),
      .axis_io_pin_oe_n(poe_n), .drive_status(ds), .sync_pulse(sp), .compare_result(cr),
      .sync_trigger(trig), .ext_rel_start(rel), .ext_cont_start(cont));

   task automatic give_verdict;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict

   task automatic chk(input logic [39:0] seen, input logic [39:0] want, input string m);
      compares++;
      if (seen !== want)
      begin
         fail_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk

   // Ready, read data and error are taken at the rising edge that samples ready high.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 16);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      if (n >= 16)
      begin
         fail_count++;
         $display("[FAIL] %0t bus timeout", $time);
         give_verdict();
      end
   endtask : apb

   task automatic watch(input logic [39:0] msk, input logic [39:0] want, input int nc);
      logic [39:0] o, ev;
      int cnt;
      o = '0;
      cnt = 0;
      repeat (8)
      begin
         @(negedge pclk);
         ev = {cont, rel, trig} & msk;
         o |= ev;
         cnt += int'(ev != 0);
      end
      @(posedge pclk);
      chk(o, want, "event set");
      if (nc >= 0)
         chk(cnt, nc, "event count");
   endtask : watch

   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(poe_n, 32'hffff_ffff, "pins driven after reset");
      apb(1'b0, 8'h10, 32'h0);
      chk(r, {16'h0, ext[15:0]}, "xy levels");
      apb(1'b0, 8'h14, 32'h0);
      chk(r, {16'h0, ext[31:16]}, "zu levels");
      apb(1'b0, 8'h40, 32'h0);
      chk({err, r}, {1'b1, 32'h0}, "unmapped read");
      apb(1'b1, 8'h10, 32'hffff);
      chk(err, 1'b1, "level write");
      $display("test reset done");
      apb(1'b1, 8'h08, {16'h0, dat[15:0]});
      apb(1'b1, 8'h0c, {16'h0, dat[31:16]});
      for (int c = 0; c < 4; c++)
      begin
         for (int i = 0; i < 32; i++)
         begin
            k = i % 8;
            cd = (c + k) % 4;
            w[2*k+:2] = cd[1:0];
            eo[i] = (cd == 0);
            ex[i] = cd == 0 ? ext[i] : cd == 1 ? dat[i] : cd == 2 ? ds[i/8][k%3] :
               k < 4 ? sp[i/8*4+k] : cr[i/8*4+k-4];
         end
         apb(1'b1, 8'h04, {16'h0, w});
         apb(1'b1, 8'h00, 32'h0f21);
         apb(1'b0, 8'h10, 32'h0);
         chk(r, {16'h0, ex[15:0]}, "xy pin levels");
         apb(1'b0, 8'h14, 32'h0);
         chk(r, {16'h0, ex[31:16]}, "zu pin levels");
         chk(poe_n, eo, "pin enables");
         chk(pout, ex & ~eo, "pin drive values");
      end
      $display("test function codes done");
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h00, 32'h0f22);
      chk(poe_n, eo, "other code applied");
      apb(1'b1, 8'h00, 32'h0f21);
      // Let the enables and the edge events of the released pins settle first.
      repeat (4) @(posedge pclk);
      chk(poe_n, 32'hffff_ffff, "inputs not released");
      ext[0] <= 1'b1;
      watch(40'hff_ffff_ffff, 40'h1, 1);
      apb(1'b1, 8'h1c, 32'h1);
      ext[0] <= 1'b0;
      watch(40'hff_ffff_ffff, 40'h1, 1);
      ext[4] <= 1'b1;
      watch(40'hff_ffff_ffff, 40'h10, 1);
      ext[4] <= 1'b0;
      watch(40'hff_ffff_ffff, 40'h0, 0);
      apb(1'b1, 8'h18, 32'h1);
      ext[4] <= 1'b1;
      watch(40'h0f_0000_0000, 40'h01_0000_0000, -1);
      chk(rel, 4'h1, "level start not held");
      apb(1'b1, 8'h18, 32'h11);
      ext[5] <= 1'b1;
      watch(40'hf0_0000_0000, 40'h10_0000_0000, 1);
      $display("test events done");
      give_verdict();
   end
endmodule : axis_gpio_function_select_test

`default_nettype wire
